// *** rtl/tmo_pkg.sv ***
package tmo_pkg;

    // ****************************************
    // Output modes
    // ****************************************
    localparam logic [2:0] MODE_DIRECT = 3'h0;
    localparam logic [2:0] MODE_SET = 3'h1;
    localparam logic [2:0] MODE_TOG_RST = 3'h2;
    localparam logic [2:0] MODE_SET_RST = 3'h3;
    localparam logic [2:0] MODE_TOGGLE = 3'h4;
    localparam logic [2:0] MODE_RESET = 3'h5;
    localparam logic [2:0] MODE_TOG_SET = 3'h6;
    localparam logic [2:0] MODE_RST_SET = 3'h7;

    // ****************************************
    // Register map (word addresses)
    // ****************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTL0 = 4'h0;
    localparam logic [3:0] REG_CTL6 = 4'h6;
    localparam logic [3:0] REG_TIMER = 4'h8;
    localparam logic [3:0] REG_VECTOR = 4'h9;
    localparam logic [3:0] REG_STATUS = 4'hA;

    // Channel control word fields
    localparam int CTL_FLAG = 0;
    localparam int CTL_IE = 1;
    localparam int CTL_LEVEL = 2;
    localparam int CTL_CAP = 3;
    localparam int CTL_MODE_LO = 4;
    localparam int CTL_MODE_HI = 6;

    // Timer control word fields
    localparam int TMR_OVF_FLAG = 0;
    localparam int TMR_OVF_IE = 1;

    // Vector codes
    localparam logic [3:0] VEC_NONE = 4'h0;
    localparam logic [3:0] VEC_OVF = 4'hE;

    typedef struct packed {
        logic [2:0] mode;
        logic cap;
        logic level;
        logic ie;
    } tmo_chan_cfg_s;

endpackage

// *** rtl/tmo_timer_out.sv ***
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// - Outputs clocked in every mode, direct mode included
// - Mode 0 drives output from level bit
// - Mode 1 sets on compare
// - Mode 2 toggles on compare, clears on period
// - Mode 3 sets on compare, clears on period
// - Mode 4 toggles on compare
// - Mode 5 clears on compare
// - Mode 6 toggles on compare, sets on period
// - Mode 7 clears on compare, sets on period
// - Up/down: compare events in both directions
// - Channel 0 request plus shared request
// - Flag set on capture or compare
// - Software may set or clear flags
// - Request needs channel enable and global enable
// - Channel 0 flag cleared on acknowledge
// - Vector codes highest enabled shared source
// - Codes 2 to 12 for channels 1 to 6, 14 overflow
// - Vector access clears highest pending flag
// - Lower channel numbers win
// - Compare equal when count hits latch
// - Overflow enable gates overflow request
module tmo_timer_out
    import tmo_pkg::*;
#(
    parameter int NCH = 7,
    parameter int CW = 16
) (
    input wire logic clk_in, // Timer clock
    input wire logic rst_n_in, // Sync reset, active low
    input wire logic [CW-1:0] timer_count_in, // Current count
    input wire logic count_step_in, // Count advanced this cycle
    input wire logic overflow_event_in, // Counter overflow event
    input wire logic [NCH-1:0] capture_event_in, // Capture performed
    input wire logic [NCH*CW-1:0] compare_latch_in, // Compare latches, ch0 = period
    input wire logic global_irq_enable_in, // CPU global enable
    input wire logic irq0_ack_in, // Channel 0 request serviced
    input wire logic [ADDR_W-1:0] addr_in, // Register address
    input wire logic [15:0] wdata_in, // Write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    output logic [15:0] rdata_out, // Read data
    output logic [NCH-1:0] output_level_out, // Channel output pins
    output logic irq0_out, // Channel 0 request
    output logic irq_shared_out // Shared request
);

    // ****************************************
    // State
    // ****************************************
    tmo_chan_cfg_s cfg [NCH];
    logic [NCH-1:0] flag;
    logic [NCH-1:0] out_q;
    logic ovf_flag;
    logic ovf_ie;

    // ****************************************
    // Compare events
    // ****************************************
    logic [NCH-1:0] cmp_eq;
    logic period_equal;
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_eq
            // Count reaching the latch; qualified by a step so a stopped counter fires once
            assign cmp_eq[g] = count_step_in && (timer_count_in == compare_latch_in[g*CW +: CW]);
        end
    endgenerate
    assign period_equal = cmp_eq[0];

    // ****************************************
    // Vector priority
    // ****************************************
    logic [NCH-1:0] pend;
    logic ovf_pend;
    logic [3:0] vec_code;
    logic [NCH-1:0] vec_clr;
    logic vec_clr_ovf;
    logic vec_access;

    logic [NCH-1:0] ie_all;

    // Enables gathered into one word; a function reading cfg without arguments
    // would hide it from the sensitivity of a continuous assignment
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ie_all[i] = cfg[i].ie;
        end
    end

    assign pend = flag & ie_all;
    assign ovf_pend = ovf_flag && ovf_ie;

    // Even-step code of a shared channel
    function automatic logic [3:0] chan_code(input int idx);
        return 4'(2 * idx);
    endfunction

    // Lowest channel number above zero wins; overflow last
    always_comb begin
        vec_code = VEC_NONE;
        vec_clr = '0;
        vec_clr_ovf = 1'b0;
        for (int i = NCH - 1; i >= 1; i--) begin
            if (pend[i]) begin
                vec_code = chan_code(i);
                vec_clr = '0;
                vec_clr[i] = 1'b1;
            end
        end
        if (vec_code == VEC_NONE && ovf_pend) begin
            vec_code = VEC_OVF;
            vec_clr_ovf = 1'b1;
        end
    end

    assign vec_access = (rd_in || wr_in) && (addr_in == REG_VECTOR);

    // ****************************************
    // Register decode
    // ****************************************
    logic is_ctl;
    logic [2:0] ch_idx;
    logic [15:0] next_rdata;
    assign is_ctl = addr_in <= REG_CTL6;
    assign ch_idx = addr_in[2:0];

    logic sel_chan;
    logic sel_timer;
    logic sel_status;
    assign sel_chan = is_ctl && int'(ch_idx) < NCH;
    assign sel_timer = addr_in == REG_TIMER;
    assign sel_status = addr_in == REG_STATUS;

    function automatic logic [15:0] ctl_word(input tmo_chan_cfg_s c, input logic f, input logic o);
        logic [15:0] w;
        w = '0;
        w[CTL_FLAG] = f;
        w[CTL_IE] = c.ie;
        w[CTL_LEVEL] = o;
        w[CTL_CAP] = c.cap;
        w[CTL_MODE_HI:CTL_MODE_LO] = c.mode;
        return w;
    endfunction

    always_comb begin
        next_rdata = '0;
        if (sel_chan) begin
            next_rdata = ctl_word(cfg[ch_idx], flag[ch_idx], out_q[ch_idx]);
        end else if (sel_timer) begin
            next_rdata[TMR_OVF_FLAG] = ovf_flag;
            next_rdata[TMR_OVF_IE] = ovf_ie;
        end else if (addr_in == REG_VECTOR) begin
            next_rdata[3:0] = vec_code;
        end else if (sel_status) begin
            next_rdata[NCH-1:0] = output_level_out;
        end
    end

    // ****************************************
    // Output units
    // ****************************************
    function automatic logic out_next(input logic [2:0] m, input logic cur, input logic eq, input logic per);
        logic n;
        n = cur;
        case (m)
            // Period event wins over compare: channel 0 sees both at once
            MODE_SET: begin
                if (eq) begin
                    n = 1'b1;
                end
            end
            MODE_TOG_RST: begin
                if (per) begin
                    n = 1'b0;
                end else if (eq) begin
                    n = ~cur;
                end
            end
            MODE_SET_RST: begin
                if (per) begin
                    n = 1'b0;
                end else if (eq) begin
                    n = 1'b1;
                end
            end
            MODE_TOGGLE: begin
                if (eq) begin
                    n = ~cur;
                end
            end
            MODE_RESET: begin
                if (eq) begin
                    n = 1'b0;
                end
            end
            MODE_TOG_SET: begin
                if (per) begin
                    n = 1'b1;
                end else if (eq) begin
                    n = ~cur;
                end
            end
            MODE_RST_SET: begin
                if (per) begin
                    n = 1'b1;
                end else if (eq) begin
                    n = 1'b0;
                end
            end
            default: begin
                n = cur;
            end
        endcase
        return n;
    endfunction

    logic [NCH-1:0] wr_ch;
    logic wr_to_direct;
    logic [NCH-1:0] mode_live;
    logic [NCH-1:0] hw_event;
    logic [NCH-1:0] next_out;
    logic [NCH-1:0] next_pin;

    // Write strobe steered to the addressed channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            wr_ch[i] = wr_in && sel_chan && int'(ch_idx) == i;
        end
    end

    // A write that selects the direct mode passes its level bit at once
    assign wr_to_direct = wdata_in[CTL_MODE_HI:CTL_MODE_LO] == MODE_DIRECT;

    // Event modes act only while a non-direct mode stays selected
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            mode_live[i] = (cfg[i].mode != MODE_DIRECT) && !(wr_ch[i] && wr_to_direct);
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            next_out[i] = out_q[i];
            if (wr_ch[i]) begin
                next_out[i] = wdata_in[CTL_LEVEL];
            end
            if (mode_live[i]) begin
                next_out[i] = out_next(cfg[i].mode, out_q[i], cmp_eq[i] && !cfg[i].cap, period_equal);
            end
            // Direct mode: the pin follows the level bit as it is written,
            // landing with the bit itself so no extra cycle appears
            next_pin[i] = next_out[i];
        end
    end

    // Flag set sources: capture in capture mode, compare equal otherwise
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            hw_event[i] = cfg[i].cap ? capture_event_in[i] : cmp_eq[i];
        end
    end

    // ****************************************
    // Flags and config
    // ****************************************
    logic [NCH-1:0] next_flag;
    logic next_ovf;
    always_comb begin
        next_flag = flag;
        next_ovf = ovf_flag;
        if (vec_access) begin
            next_flag = next_flag & ~vec_clr;
            next_ovf = next_ovf && !vec_clr_ovf;
        end
        if (irq0_ack_in) begin
            next_flag[0] = 1'b0;
        end
        if (wr_in && sel_chan) begin
            next_flag[ch_idx] = wdata_in[CTL_FLAG];
        end
        if (wr_in && sel_timer) begin
            next_ovf = wdata_in[TMR_OVF_FLAG];
        end
        // Hardware events win over any clear in the same cycle
        next_flag = next_flag | hw_event;
        if (overflow_event_in) begin
            next_ovf = 1'b1;
        end
    end

    // ****************************************
    // Interrupt requests
    // ****************************************
    logic [NCH-1:0] gated_req;
    logic next_irq0;
    logic next_irq_shared;
    // Requests follow the flags as they land, so a clear drops them at the same edge
    assign gated_req = next_flag & ie_all;
    assign next_irq0 = gated_req[0] && global_irq_enable_in;
    assign next_irq_shared = global_irq_enable_in && ((|gated_req[NCH-1:1]) || (next_ovf && ovf_ie));

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NCH; i++) begin
                cfg[i] <= '0;
            end
            ovf_ie <= 1'b0;
        end else begin
            // A new event mode acts from the next cycle on; the direct mode acts in the write cycle
            for (int i = 0; i < NCH; i++) begin
                if (wr_ch[i]) begin
                    cfg[i].ie <= wdata_in[CTL_IE];
                    cfg[i].cap <= wdata_in[CTL_CAP];
                    cfg[i].mode <= wdata_in[CTL_MODE_HI:CTL_MODE_LO];
                end
            end
            if (wr_in && sel_timer) begin
                ovf_ie <= wdata_in[TMR_OVF_IE];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            flag <= '0;
            ovf_flag <= 1'b0;
        end else begin
            flag <= next_flag;
            ovf_flag <= next_ovf;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            out_q <= '0;
            output_level_out <= '0;
        end else begin
            out_q <= next_out;
            output_level_out <= next_pin;
        end
    end

    // Read data stand for one cycle only; zero otherwise keeps the bus quiet
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= rd_in ? next_rdata : 16'h0000;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq0_out <= 1'b0;
            irq_shared_out <= 1'b0;
        end else begin
            irq0_out <= next_irq0;
            irq_shared_out <= next_irq_shared;
        end
    end

endmodule

// *** bench/tmo_cpu_model.sv ***
`timescale 1ns/1ps
module tmo_cpu_model (
    input wire logic clk_in, // Timer clock
    input wire logic rst_n_in, // Sync reset, active low
    input wire logic irq0_in, // Channel 0 request
    output logic irq0_ack_out // Service pulse
);
    // ****************************************
    // Service of the dedicated request
    // ****************************************
    logic irq0_seen;
    // One service per rising request; a held level is not serviced twice
    always_ff @(posedge clk_in) begin
        irq0_seen <= rst_n_in && irq0_in;
        irq0_ack_out <= rst_n_in && irq0_in && !irq0_seen;
    end
endmodule

// *** bench/tmo_timer_out_checker.sv ***
`timescale 1ns/1ps
module tmo_timer_out_checker
    import tmo_pkg::*;
#(
    parameter int NCH = 7,
    parameter int CW = 16
) (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic count_step_in, // Step
    input wire logic overflow_event_in, // Overflow
    input wire logic [NCH-1:0] capture_event_in, // Captures
    input wire logic global_irq_enable_in, // Global enable
    input wire logic irq0_ack_in, // Service
    input wire logic [ADDR_W-1:0] addr_in, // Address
    input wire logic wr_in, // Write
    input wire logic rd_in, // Read
    input wire logic [15:0] rdata_out, // Read data
    input wire logic [NCH-1:0] output_level_out, // Pins
    input wire logic irq0_out, // Channel 0 request
    input wire logic irq_shared_out // Shared request
);
    // ****************************************
    // Port relations
    // ****************************************
    // Nothing may set a flag again while these hold
    wire quiet0 = !count_step_in && !capture_event_in[0] && !wr_in;
    wire quiet_all = !count_step_in && capture_event_in == '0 && !wr_in && !overflow_event_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_vec_rd;
        rd_in && addr_in == REG_VECTOR && quiet_all;
    endsequence
    sequence s_ack_quiet;
        (irq0_ack_in && quiet0) ##1 quiet0;
    endsequence
    a_irq0_gated: assert property (!global_irq_enable_in [*2] |-> !irq0_out)
        else $error("channel 0 request without global enable");
    a_shared_gated: assert property (!global_irq_enable_in [*2] |-> !irq_shared_out)
        else $error("shared request without global enable");
    a_vec_code: assert property (s_vec_rd |=> rdata_out <= 16'h000E && !rdata_out[0])
        else $error("vector code out of range");
    a_vec_advance: assert property (s_vec_rd ##1 s_vec_rd |=> rdata_out == 16'h0000 || rdata_out != $past(rdata_out))
        else $error("vector access did not clear its flag");
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 16'h0000)
        else $error("read data outside read cycle");
    a_ack_clears: assert property (s_ack_quiet |=> !irq0_out)
        else $error("channel 0 request survives service");
    a_pin_cause: assert property ($changed(output_level_out) |-> $past(wr_in) || $past(count_step_in))
        else $error("pin changed without write or count step");
    a_status_pins: assert property (rd_in && addr_in == REG_STATUS |=> rdata_out[NCH-1:0] == $past(output_level_out))
        else $error("status read differs from pins");
endmodule
bind tmo_timer_out tmo_timer_out_checker #(.NCH(NCH), .CW(CW)) u_tmo_timer_out_checker (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .count_step_in(count_step_in), .overflow_event_in(overflow_event_in),
    .capture_event_in(capture_event_in), .global_irq_enable_in(global_irq_enable_in), .irq0_ack_in(irq0_ack_in),
    .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .output_level_out(output_level_out),
    .irq0_out(irq0_out), .irq_shared_out(irq_shared_out)
);

// *** bench/timer_output_and_irq_vector_test.sv ***
`timescale 1ns/1ps
module timer_output_and_irq_vector_test;
    import tmo_pkg::*;
    // ****************************************
    // Bench
    // ****************************************
    logic clk_in = 1'b0, rst_n_in = 1'b0, count_step_in = 1'b0, overflow_event_in = 1'b0;
    logic global_irq_enable_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, irq0_ack_in, irq0_out, irq_shared_out;
    logic [6:0] capture_event_in = '0, output_level_out;
    logic [111:0] compare_latch_in = {{5{16'h0100}}, 16'h0005, 16'h0009};
    logic [3:0] addr_in = '0;
    logic [15:0] timer_count_in = '0, wdata_in = '0, rdata_out;
    int err_total = 0, tests_run = 0;
    always #2 clk_in = ~clk_in;
    tmo_timer_out u_tmo_timer_out (.clk_in(clk_in), .rst_n_in(rst_n_in), .timer_count_in(timer_count_in),
        .count_step_in(count_step_in), .overflow_event_in(overflow_event_in), .capture_event_in(capture_event_in),
        .compare_latch_in(compare_latch_in), .global_irq_enable_in(global_irq_enable_in), .irq0_ack_in(irq0_ack_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .output_level_out(output_level_out), .irq0_out(irq0_out), .irq_shared_out(irq_shared_out));
    tmo_cpu_model u_tmo_cpu_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .irq0_in(irq0_out), .irq0_ack_out(irq0_ack_in));
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp, nm);
    endtask
    task automatic ev(input logic [15:0] cnt);
        timer_count_in <= cnt;
        count_step_in <= 1'b1;
        @(posedge clk_in);
        count_step_in <= 1'b0;
        #1;
    endtask
    task automatic wait_irq0(input logic lvl);
        for (int i = 0; i < 20 && irq0_out !== lvl; i++) begin
            @(posedge clk_in);
            #1;
        end
        chk(16'(irq0_out), 16'(lvl), "irq0 level");
        if (irq0_out !== lvl)
            test_done();
    endtask
    // Pin after one event: compare op, or period op when per is set
    function automatic logic nxt(input logic [2:0] m, input logic v, input logic per);
        if (per)
            return (m inside {3'h2, 3'h3}) ? 1'b0 : (m inside {3'h6, 3'h7}) ? 1'b1 : v;
        return (m inside {3'h1, 3'h3}) ? 1'b1 : (m inside {3'h5, 3'h7}) ? 1'b0 : ~v;
    endfunction
    task automatic t_modes;
        logic e;
        for (int l = 0; l < 2; l++) begin
            for (int m = 1; m < 8; m++) begin
                wr(4'h1, 16'h0002 | (16'(l) << 2));
                chk(16'(output_level_out[1]), 16'(l), "direct pin");
                rd(REG_STATUS, 16'(l) << 1, "status");
                wr(4'h1, 16'h0002 | (16'(m) << 4) | (16'(l) << 2));
                e = nxt(3'(m), 1'(l), 1'b0);
                ev(16'h0005);
                chk(16'(output_level_out[1]), 16'(e), "compare pin");
                chk(16'(irq_shared_out), 16'h0001, "shared irq");
                rd(REG_VECTOR, 16'h0002, "vector ch1");
                ev(16'h0009);
                e = nxt(3'(m), e, 1'b1);
                chk(16'(output_level_out[1]), 16'(e), "period pin");
                ev(16'h0005);
                chk(16'(output_level_out[1]), 16'(nxt(3'(m), e, 1'b0)), "second compare pin");
                rd(REG_VECTOR, 16'h0002, "vector ch1 again");
            end
        end
    endtask
    task automatic t_vector;
        wr(4'h1, 16'h0003);
        wr(4'h2, 16'h000A);
        capture_event_in <= 7'h04;
        @(posedge clk_in);
        capture_event_in <= '0;
        wr(4'h3, 16'h0001);
        for (int i = 4; i < 7; i++)
            wr(4'(i), 16'h0003);
        wr(REG_TIMER, 16'h0002);
        overflow_event_in <= 1'b1;
        @(posedge clk_in);
        overflow_event_in <= 1'b0;
        #1;
        chk(16'(irq_shared_out), 16'h0001, "shared pending");
        wr(REG_VECTOR, 16'h0000);
        rd(REG_VECTOR, 16'h0004, "vector capture ch2");
        for (int i = 4; i < 7; i++)
            rd(REG_VECTOR, 16'(2 * i), "vector upper ch");
        rd(REG_VECTOR, 16'(VEC_OVF), "vector overflow");
        rd(REG_VECTOR, 16'(VEC_NONE), "vector empty");
        chk(16'(irq_shared_out), 16'h0000, "shared idle");
    endtask
    task automatic t_irq0;
        global_irq_enable_in <= 1'b0;
        wr(REG_CTL0, 16'h0003);
        #10;
        chk(16'(irq0_out), 16'h0000, "irq0 masked");
        global_irq_enable_in <= 1'b1;
        wait_irq0(1'b1);
        wait_irq0(1'b0);
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        #1;
        t_modes();
        t_vector();
        t_irq0();
        test_done();
    end
endmodule
